// file: core/osg_edge_latch.sv
// Rising-edge event latch with clear on read
`timescale 1ns/1ps
module osg_edge_latch (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] cond_i,
  input  wire logic [31:0] enable_i,
  input  wire logic        clear_i,
  output logic      [31:0] event_o
);
  osg_pkg::osg_latch_s st_r;
  osg_pkg::osg_latch_s st_nxt;
  logic [31:0]         rise;

  // ------------------------------------------------------------
  // Per-bit edge detect
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      assign rise[i] = cond_i[i] & ~st_r.prev[i] & enable_i[i] & osg_pkg::USED_BITS[i];
    end
  endgenerate

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = cond_i;
    // Set after clear so a coinciding edge survives the read
    st_nxt.evt  = (clear_i ? osg_pkg::EVENT_RST : st_r.evt) | rise;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign event_o = st_r.evt;
endmodule : osg_edge_latch

// file: core/osg_top.sv
// Operation status event group: condition assembly, event latch, alarm and command port
`timescale 1ns/1ps
module osg_top (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  // Operating state from the instrument's own logic
  input  osg_pkg::osg_status_s            status_i,
  input  wire logic [31:0]                fault_cond_i,
  input  wire logic [31:0]                fault_enable_i,
  input  osg_pkg::osg_mode_e              mode_i,
  input  wire logic [osg_pkg::VOLT_W-1:0] setpoint_i,
  input  wire logic [osg_pkg::VOLT_W-1:0] measured_i,
  // Rear-panel pins, asynchronous
  input  wire logic                       ext_shutdown_pin_i,
  input  wire logic                       interlock_pin_i,
  // Decoded host command
  input  wire logic                       cmd_valid_i,
  input  osg_pkg::osg_op_e                cmd_op_i,
  input  osg_pkg::osg_mode_e              cmd_sel_i,
  input  wire logic [31:0]                cmd_data_i,
  output logic                            resp_valid_o,
  output logic                            resp_err_o,
  output logic [31:0]                     resp_data_o,
  // Protection outputs
  output logic                            alarm_o,
  output logic                            undervoltage_trip_o,
  output logic                            setpoint_block_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  osg_pkg::osg_top_s st_r;
  osg_pkg::osg_top_s st_nxt;
  osg_pkg::osg_uv_s  uv_st;
  logic [31:0]       cond;
  logic [31:0]       event_bits;
  logic              ev_clear;
  logic              uv_wr_level;
  logic              uv_wr_state;
  logic              uv_level_ok;
  logic              ext_shutdown_active;
  logic              interlock_active;
  logic              no_fault_flag;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Second stage only feeds logic; first stage is read by nothing else
  assign ext_shutdown_active = st_r.sync2[0];
  assign interlock_active    = st_r.sync2[1];

  // ------------------------------------------------------------
  // Command strobes
  // ------------------------------------------------------------
  assign ev_clear    = cmd_valid_i && (cmd_op_i == osg_pkg::OP_RD_EVENT);
  assign uv_wr_level = cmd_valid_i && (cmd_op_i == osg_pkg::OP_WR_UV_LEVEL);
  assign uv_wr_state = cmd_valid_i && (cmd_op_i == osg_pkg::OP_WR_UV_STATE);

  // ------------------------------------------------------------
  // Condition assembly
  // ------------------------------------------------------------
  assign no_fault_flag = ~|(fault_cond_i & fault_enable_i);

  always_comb begin
    cond = '0;
    cond[osg_pkg::BIT_CV]        = status_i.cv;
    cond[osg_pkg::BIT_CC]        = status_i.cc;
    cond[osg_pkg::BIT_NOFAULT]   = no_fault_flag;
    cond[osg_pkg::BIT_DCSEQ_TW]  = status_i.dc_sequence_trigger_wait;
    cond[osg_pkg::BIT_AUTORUN]   = status_i.autorun_armed;
    cond[osg_pkg::BIT_ESTOP]     = status_i.estop_armed;
    cond[osg_pkg::BIT_DCSEQ_RUN] = status_i.dc_sequence_running;
    cond[osg_pkg::BIT_LOCAL]     = status_i.front_panel_mode;
    cond[osg_pkg::BIT_UV_AC]     = uv_st.arm_ac;
    cond[osg_pkg::BIT_ILK_ARM]   = status_i.interlock_armed;
    cond[osg_pkg::BIT_SHD_ARM]   = status_i.ext_shutdown_armed;
    cond[osg_pkg::BIT_CFB]       = status_i.current_foldback_on;
    cond[osg_pkg::BIT_AVREF]     = status_i.analog_voltage_reference;
    cond[osg_pkg::BIT_CPT]       = status_i.current_protection_tripped;
    cond[osg_pkg::BIT_STEP_TW]   = status_i.stepper_trigger_wait;
    cond[osg_pkg::BIT_BURST_TW]  = status_i.burst_trigger_wait;
    cond[osg_pkg::BIT_TABLE_TW]  = status_i.table_trigger_wait;
    cond[osg_pkg::BIT_BURST_RUN] = (status_i.burst_state == osg_pkg::SEQ_ACTIVE) ||
                                   (status_i.burst_state == osg_pkg::SEQ_INACTIVE);
    cond[osg_pkg::BIT_TABLE_RUN] = status_i.table_state == osg_pkg::SEQ_ACTIVE;
    cond[osg_pkg::BIT_VFB]       = status_i.voltage_foldback_on;
    // Shutdown only counts while the function is armed
    cond[osg_pkg::BIT_ILK_ACT]   = interlock_active && status_i.interlock_armed;
    cond[osg_pkg::BIT_SHD_ACT]   = ext_shutdown_active && status_i.ext_shutdown_armed;
    cond[osg_pkg::BIT_UV_DC]     = uv_st.arm_dc;
    cond[osg_pkg::BIT_UV_MIX]    = uv_st.arm_mixed;
    cond = cond & osg_pkg::USED_BITS;
  end

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  osg_edge_latch u_latch (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .cond_i   (cond),
    .enable_i (st_r.op_enable),
    .clear_i  (ev_clear),
    .event_o  (event_bits)
  );

  osg_uv_guard u_uv (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .mode_i     (mode_i),
    .setpoint_i (setpoint_i),
    .measured_i (measured_i),
    .wr_level_i (uv_wr_level),
    .wr_state_i (uv_wr_state),
    .sel_i      (cmd_sel_i),
    .data_i     (cmd_data_i[osg_pkg::VOLT_W-1:0]),
    .level_ok_o (uv_level_ok),
    .state_o    (uv_st)
  );

  // ------------------------------------------------------------
  // Command decode and next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt            = st_r;
    st_nxt.sync1      = {interlock_pin_i, ext_shutdown_pin_i};
    st_nxt.sync2      = st_r.sync1;
    st_nxt.resp_valid = cmd_valid_i;
    st_nxt.resp_err   = 1'b0;
    // Alarm sources are the live conditions and the latched events
    st_nxt.alarm      = |(st_r.alarm_mask & (cond | event_bits));
    if (cmd_valid_i) begin
      st_nxt.resp_data = '0;
      unique case (cmd_op_i)
        osg_pkg::OP_NOP: begin
          st_nxt.resp_data = '0;
        end
        osg_pkg::OP_WR_ALARM: begin
          st_nxt.alarm_mask = cmd_data_i;
        end
        osg_pkg::OP_RD_ALARM: begin
          st_nxt.resp_data = st_r.alarm_mask;
        end
        osg_pkg::OP_WR_ENABLE: begin
          st_nxt.op_enable = cmd_data_i;
        end
        osg_pkg::OP_RD_ENABLE: begin
          st_nxt.resp_data = st_r.op_enable;
        end
        osg_pkg::OP_RD_EVENT: begin
          // Snapshot before clear; no write path exists for this register
          st_nxt.resp_data = event_bits;
        end
        osg_pkg::OP_RD_COND: begin
          st_nxt.resp_data = cond;
        end
        osg_pkg::OP_WR_UV_LEVEL: begin
          st_nxt.resp_err = !uv_level_ok;
        end
        osg_pkg::OP_RD_UV_LEVEL: begin
          unique case (cmd_sel_i)
            osg_pkg::MODE_AC: st_nxt.resp_data = 32'(uv_st.thr_ac);
            osg_pkg::MODE_DC: st_nxt.resp_data = 32'(uv_st.thr_dc);
            default:          st_nxt.resp_data = 32'(uv_st.thr_mixed);
          endcase
        end
        osg_pkg::OP_WR_UV_STATE: begin
          st_nxt.resp_data = '0;
        end
        osg_pkg::OP_RD_UV_STATE: begin
          unique case (cmd_sel_i)
            osg_pkg::MODE_AC: st_nxt.resp_data = 32'(uv_st.arm_ac);
            osg_pkg::MODE_DC: st_nxt.resp_data = 32'(uv_st.arm_dc);
            default:          st_nxt.resp_data = 32'(uv_st.arm_mixed);
          endcase
        end
        default: begin
          // Undefined opcodes are answered with an error and change nothing
          st_nxt.resp_err = 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r            <= '0;
      st_r.alarm_mask <= osg_pkg::ALARM_MASK_RST;
      st_r.op_enable  <= osg_pkg::OP_ENABLE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign resp_valid_o        = st_r.resp_valid;
  assign resp_err_o          = st_r.resp_err;
  assign resp_data_o         = st_r.resp_data;
  assign alarm_o             = st_r.alarm;
  assign undervoltage_trip_o = uv_st.trip;
  assign setpoint_block_o    = uv_st.block;

endmodule : osg_top

// file: core/osg_uv_guard.sv
// Undervoltage threshold, arm state and trip decision
`timescale 1ns/1ps
module osg_uv_guard (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  osg_pkg::osg_mode_e              mode_i,
  input  wire logic [osg_pkg::VOLT_W-1:0] setpoint_i,
  input  wire logic [osg_pkg::VOLT_W-1:0] measured_i,
  input  wire logic                       wr_level_i,
  input  wire logic                       wr_state_i,
  input  osg_pkg::osg_mode_e              sel_i,
  input  wire logic [osg_pkg::VOLT_W-1:0] data_i,
  output logic                            level_ok_o,
  output osg_pkg::osg_uv_s                state_o
);
  osg_pkg::osg_uv_s  st_r;
  osg_pkg::osg_uv_s  st_nxt;
  localparam int VW = osg_pkg::VOLT_W;
  logic [VW-1:0]     thr_now;
  logic              arm_now;
  logic              inhibit;

  // Threshold no higher than setpoint / 1.05, done as integer cross-multiply
  assign level_ok_o = (32'(data_i) * osg_pkg::SP_DIV_NUM) <= (32'(setpoint_i) * osg_pkg::SP_DIV_DEN);

  always_comb begin
    unique case (mode_i)
      osg_pkg::MODE_AC: begin
        thr_now = st_r.thr_ac;
        arm_now = st_r.arm_ac;
      end
      osg_pkg::MODE_DC: begin
        thr_now = st_r.thr_dc;
        arm_now = st_r.arm_dc;
      end
      default: begin
        thr_now = st_r.thr_mixed;
        arm_now = st_r.arm_mixed;
      end
    endcase
  end

  assign inhibit = (32'(thr_now) * osg_pkg::PCT_FULL) < (osg_pkg::RATED_VOLT * osg_pkg::MIN_PCT);

  always_comb begin
    st_nxt = st_r;
    if (wr_level_i && level_ok_o) begin
      unique case (sel_i)
        osg_pkg::MODE_AC: st_nxt.thr_ac = data_i;
        osg_pkg::MODE_DC: st_nxt.thr_dc = data_i;
        default:          st_nxt.thr_mixed = data_i;
      endcase
    end
    if (wr_state_i) begin
      unique case (sel_i)
        osg_pkg::MODE_AC: st_nxt.arm_ac = data_i[0];
        osg_pkg::MODE_DC: st_nxt.arm_dc = data_i[0];
        default:          st_nxt.arm_mixed = data_i[0];
      endcase
    end
    st_nxt.block = setpoint_i < thr_now;
    st_nxt.trip  = arm_now && !inhibit && (measured_i <= thr_now);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign state_o = st_r;
endmodule : osg_uv_guard

// file: inc/osg_pkg.sv
// Constants, types and state records of the operation status event group
// How it works
// - Thirty-two bit alarm mask selects alarm sources
// - Read-only event register from condition and enable
// - Event bit sets only on rising condition
// - Reading events returns content then clears all; a rising edge in the read cycle still sets its bit
// - Bits 31-27, 22, 15, 14 never set
// - Bits 8/25/26: undervoltage armed AC/DC/mixed
// - Bit 24 shutdown active, bit 10 armed
// - Bit 23 interlock active, bit 9 armed
// - Bit 21 voltage foldback, bit 11 current foldback
// - Bit 13 current protection fault activated
// - Bit 12 analog voltage reference selected
// - Bit 20 only while table sequencer active
// - Bit 19 burst sequencer active or inactive
// - Bits 18/17/16 table/burst/stepper trigger wait
// - Bit 6 DC sequence running, bit 3 waiting
// - Bit 7 set under front-panel control
// - Bit 5 emergency stop armed, bit 4 autorun
// - Bit 2 when no enabled fault present
// - Threshold accepted only up to setpoint/1.05
// - Setpoints below threshold blocked in either arm state, arm 1 trips output
// - Enable mask gates conditions into events
// - No trip when threshold below 5% rating
package osg_pkg;

  // ------------------------------------------------------------
  // Register reset values and bit positions
  // ------------------------------------------------------------
  localparam logic [31:0] ALARM_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] OP_ENABLE_RST  = 32'h0000_0000;
  localparam logic [31:0] EVENT_RST      = 32'h0000_0000;
  localparam logic [31:0] USED_BITS      = 32'h07bf_3fff;
  localparam int BIT_CV        = 0;
  localparam int BIT_CC        = 1;
  localparam int BIT_NOFAULT   = 2;
  localparam int BIT_DCSEQ_TW  = 3;
  localparam int BIT_AUTORUN   = 4;
  localparam int BIT_ESTOP     = 5;
  localparam int BIT_DCSEQ_RUN = 6;
  localparam int BIT_LOCAL     = 7;
  localparam int BIT_UV_AC     = 8;
  localparam int BIT_ILK_ARM   = 9;
  localparam int BIT_SHD_ARM   = 10;
  localparam int BIT_CFB       = 11;
  localparam int BIT_AVREF     = 12;
  localparam int BIT_CPT       = 13;
  localparam int BIT_STEP_TW   = 16;
  localparam int BIT_BURST_TW  = 17;
  localparam int BIT_TABLE_TW  = 18;
  localparam int BIT_BURST_RUN = 19;
  localparam int BIT_TABLE_RUN = 20;
  localparam int BIT_VFB       = 21;
  localparam int BIT_ILK_ACT   = 23;
  localparam int BIT_SHD_ACT   = 24;
  localparam int BIT_UV_DC     = 25;
  localparam int BIT_UV_MIX    = 26;

  // ------------------------------------------------------------
  // Undervoltage scaling (volts in tenths)
  // ------------------------------------------------------------
  localparam int VOLT_W = 16;
  localparam logic [31:0] RATED_VOLT   = 32'h0000_0dac;
  localparam logic [31:0] SP_DIV_NUM   = 32'h0000_0069;
  localparam logic [31:0] SP_DIV_DEN   = 32'h0000_0064;
  localparam logic [31:0] MIN_PCT      = 32'h0000_0005;
  localparam logic [31:0] PCT_FULL     = 32'h0000_0064;
  localparam logic [VOLT_W-1:0] UV_THR_RST = 16'h0000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP, OP_WR_ALARM, OP_RD_ALARM, OP_WR_ENABLE, OP_RD_ENABLE, OP_RD_EVENT,
    OP_RD_COND, OP_WR_UV_LEVEL, OP_RD_UV_LEVEL, OP_WR_UV_STATE, OP_RD_UV_STATE
  } osg_op_e;
  typedef enum logic [1:0] {MODE_AC, MODE_DC, MODE_MIXED} osg_mode_e;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ACTIVE, SEQ_INACTIVE} osg_seq_e;

  typedef struct packed {
    logic      cv;
    logic      cc;
    logic      dc_sequence_trigger_wait;
    logic      autorun_armed;
    logic      estop_armed;
    logic      dc_sequence_running;
    logic      front_panel_mode;
    logic      interlock_armed;
    logic      ext_shutdown_armed;
    logic      current_foldback_on;
    logic      analog_voltage_reference;
    logic      current_protection_tripped;
    logic      stepper_trigger_wait;
    logic      burst_trigger_wait;
    logic      table_trigger_wait;
    osg_seq_e  burst_state;
    osg_seq_e  table_state;
    logic      voltage_foldback_on;
  } osg_status_s;

  typedef struct packed {
    logic [31:0] prev;
    logic [31:0] evt;
  } osg_latch_s;

  typedef struct packed {
    logic [VOLT_W-1:0] thr_ac;
    logic [VOLT_W-1:0] thr_dc;
    logic [VOLT_W-1:0] thr_mixed;
    logic              arm_ac;
    logic              arm_dc;
    logic              arm_mixed;
    logic              trip;
    logic              block;
  } osg_uv_s;

  typedef struct packed {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [31:0] alarm_mask;
    logic [31:0] op_enable;
    logic        resp_valid;
    logic        resp_err;
    logic [31:0] resp_data;
    logic        alarm;
  } osg_top_s;

endpackage : osg_pkg

// file: tb/osg_chk.sv
// Port-level assertions for the operation status event group
`timescale 1ns/1ps
module osg_chk (
  input wire logic          mclk_i,
  input wire logic          rst_i,
  input osg_pkg::osg_status_s status_i,
  input wire logic [31:0]   fault_cond_i,
  input wire logic [31:0]   fault_enable_i,
  input osg_pkg::osg_mode_e mode_i,
  input wire logic [15:0]   setpoint_i,
  input wire logic          ext_shutdown_pin_i,
  input wire logic          interlock_pin_i,
  input wire logic          cmd_valid_i,
  input osg_pkg::osg_op_e   cmd_op_i,
  input osg_pkg::osg_mode_e cmd_sel_i,
  input wire logic [31:0]   cmd_data_i,
  input wire logic          resp_valid_o,
  input wire logic          resp_err_o,
  input wire logic [31:0]   resp_data_o,
  input wire logic          alarm_o,
  input wire logic          undervoltage_trip_o,
  input wire logic          setpoint_block_o
);
  logic        lvl_w, lvl_ok, lvl_low, rdc, rde, alm_w, nf;
  logic [15:0] lvl_d;
  assign lvl_d   = cmd_data_i[15:0];
  assign lvl_w   = cmd_valid_i && cmd_op_i == osg_pkg::OP_WR_UV_LEVEL;
  assign lvl_ok  = {16'h0, lvl_d} * osg_pkg::SP_DIV_NUM <= {16'h0, setpoint_i} * osg_pkg::SP_DIV_DEN;
  assign lvl_low = {16'h0, lvl_d} * osg_pkg::PCT_FULL < osg_pkg::RATED_VOLT * osg_pkg::MIN_PCT;
  assign rdc     = cmd_valid_i && cmd_op_i == osg_pkg::OP_RD_COND;
  assign rde     = rdc || (cmd_valid_i && cmd_op_i == osg_pkg::OP_RD_EVENT);
  assign alm_w   = cmd_valid_i && cmd_op_i == osg_pkg::OP_WR_ALARM;
  assign nf      = (fault_cond_i & fault_enable_i) == 32'h0;

  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Mask write followed by one quiet cycle, so the new mask alone decides the alarm
  sequence mask_s(v);
    alm_w && cmd_data_i == v ##1 !alm_w;
  endsequence
  sequence thr_s;
    lvl_w && lvl_ok && cmd_sel_i == mode_i ##1 $stable(mode_i) && !lvl_w;
  endsequence

  AST_RESP_LAT: assert property (cmd_valid_i |=> resp_valid_o)
    else $error("command without response");
  AST_LVL_REJ: assert property (lvl_w && !lvl_ok |=> resp_err_o)
    else $error("threshold above limit accepted");
  AST_LVL_OK: assert property (lvl_w && lvl_ok |=> !resp_err_o)
    else $error("legal threshold refused");
  AST_UNUSED: assert property (rde |=> (resp_data_o & ~osg_pkg::USED_BITS) == 32'h0)
    else $error("unused status bit set");
  AST_ILK: assert property ((interlock_pin_i && status_i.interlock_armed)[*3] ##0 rdc |=> resp_data_o[23])
    else $error("interlock active bit missing");
  AST_NO_FAULT_FLAG: assert property (rdc |=> resp_data_o[2] == $past(nf))
    else $error("no fault bit wrong");
  AST_ALM_OFF: assert property (mask_s(32'h0) |=> !alarm_o)
    else $error("alarm with empty mask");
  AST_ALM_ON: assert property (mask_s(32'hffff_ffff) ##0 status_i.cv |=> alarm_o)
    else $error("alarm missing with full mask");
  AST_BLOCK: assert property (thr_s ##0 setpoint_i < $past(lvl_d) |=> setpoint_block_o)
    else $error("setpoint below threshold not blocked");
  AST_UV_LOW: assert property (lvl_low ##0 thr_s |=> !undervoltage_trip_o)
    else $error("trip with threshold below minimum");
endmodule : osg_chk

// file: tb/tb_top.sv
// Randomised self-checking bench for the operation status event group
`timescale 1ns/1ps
module tb_top;
  logic                 mclk_i, rst_i, cmd_valid_i, ext_shutdown_pin_i, interlock_pin_i;
  logic                 resp_valid_o, resp_err_o, alarm_o, undervoltage_trip_o, setpoint_block_o;
  logic [31:0]          fault_cond_i, fault_enable_i, cmd_data_i, resp_data_o;
  logic [15:0]          setpoint_i, measured_i;
  osg_pkg::osg_status_s st;
  osg_pkg::osg_mode_e   mode_i, cmd_sel_i;
  osg_pkg::osg_op_e     cmd_op_i;
  logic [31:0]          m_mask, m_en, m_evt, m_prev, m_rdata, cnd, seed;
  logic [2:0][15:0]     m_thr;
  logic [2:0]           m_arm;
  logic [1:0]           s_shd, s_ilk;
  logic                 m_rv, m_err, m_alm, m_trip, m_blk;
  int                   err_total, comparisons;

  osg_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .status_i(st), .fault_cond_i(fault_cond_i),
    .fault_enable_i(fault_enable_i), .mode_i(mode_i), .setpoint_i(setpoint_i), .measured_i(measured_i),
    .ext_shutdown_pin_i(ext_shutdown_pin_i), .interlock_pin_i(interlock_pin_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_sel_i(cmd_sel_i), .cmd_data_i(cmd_data_i), .resp_valid_o(resp_valid_o),
    .resp_err_o(resp_err_o), .resp_data_o(resp_data_o), .alarm_o(alarm_o),
    .undervoltage_trip_o(undervoltage_trip_o), .setpoint_block_o(setpoint_block_o));

  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  assign cnd = {5'h00, m_arm[2], m_arm[1], s_shd[1] & st.ext_shutdown_armed, s_ilk[1] & st.interlock_armed, 1'b0,
    st.voltage_foldback_on, st.table_state == osg_pkg::SEQ_ACTIVE, st.burst_state != osg_pkg::SEQ_IDLE,
    st.table_trigger_wait, st.burst_trigger_wait, st.stepper_trigger_wait, 2'b00, st.current_protection_tripped,
    st.analog_voltage_reference, st.current_foldback_on, st.ext_shutdown_armed, st.interlock_armed, m_arm[0],
    st.front_panel_mode, st.dc_sequence_running, st.estop_armed, st.autorun_armed, st.dc_sequence_trigger_wait,
    (fault_cond_i & fault_enable_i) == 32'h0, st.cc, st.cv};

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {m_mask, m_en, m_evt, m_prev, m_rdata, m_thr, m_arm} <= '0;
      {s_shd, s_ilk, m_rv, m_err, m_alm, m_trip, m_blk} <= '0;
    end else begin
      m_rv <= cmd_valid_i;
      m_err <= 1'b0;
      m_alm <= |(m_mask & (cnd | m_evt));
      // Trip only when armed and the threshold is at least the minimum share of the rating
      m_trip <= m_arm[mode_i] && measured_i <= m_thr[mode_i] &&
                32'(m_thr[mode_i]) * osg_pkg::PCT_FULL >= osg_pkg::RATED_VOLT * osg_pkg::MIN_PCT;
      m_blk <= setpoint_i < m_thr[mode_i];
      // Set wins over the read clear, so an edge during a read is kept
      m_evt <= (cmd_valid_i && cmd_op_i == osg_pkg::OP_RD_EVENT ? 32'h0 : m_evt)
               | (cnd & ~m_prev & m_en & osg_pkg::USED_BITS);
      m_prev <= cnd;
      s_shd <= {s_shd[0], ext_shutdown_pin_i};
      s_ilk <= {s_ilk[0], interlock_pin_i};
      if (cmd_valid_i) begin
        m_rdata <= 32'h0;
        case (cmd_op_i)
          osg_pkg::OP_NOP: ;
          osg_pkg::OP_WR_ALARM: m_mask <= cmd_data_i;
          osg_pkg::OP_RD_ALARM: m_rdata <= m_mask;
          osg_pkg::OP_WR_ENABLE: m_en <= cmd_data_i;
          osg_pkg::OP_RD_ENABLE: m_rdata <= m_en;
          osg_pkg::OP_RD_EVENT: m_rdata <= m_evt;
          osg_pkg::OP_RD_COND: m_rdata <= cnd;
          osg_pkg::OP_WR_UV_LEVEL: begin
            if ({16'h0, cmd_data_i[15:0]} * 32'h69 > {16'h0, setpoint_i} * 32'h64) m_err <= 1'b1;
            else m_thr[cmd_sel_i] <= cmd_data_i[15:0];
          end
          osg_pkg::OP_RD_UV_LEVEL: m_rdata <= {16'h0, m_thr[cmd_sel_i]};
          osg_pkg::OP_WR_UV_STATE: m_arm[cmd_sel_i] <= cmd_data_i[0];
          osg_pkg::OP_RD_UV_STATE: m_rdata <= {31'h0, m_arm[cmd_sel_i]};
          default: m_err <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic drive();
    logic [31:0] r, q, c;
    r = rnd();
    q = rnd();
    c = rnd();
    if (r[1:0] == 2'b00) st = osg_pkg::osg_status_s'(q[19:0]);
    if (st.burst_state == 2'h3) st.burst_state = osg_pkg::SEQ_INACTIVE;
    if (st.table_state == 2'h3) st.table_state = osg_pkg::SEQ_ACTIVE;
    if (r[3:2] == 2'b00) fault_cond_i = r[4] ? 32'h0 : rnd();
    if (r[6:5] == 2'b00) fault_enable_i = rnd();
    if (r[8:7] == 2'b00) mode_i = osg_pkg::osg_mode_e'(r[10:9] == 2'h3 ? 2'h1 : r[10:9]);
    if (r[14:11] == 4'h0) interlock_pin_i = ~interlock_pin_i;
    if (r[18:15] == 4'h0) ext_shutdown_pin_i = ~ext_shutdown_pin_i;
    setpoint_i = {4'h0, r[30:19]};
    measured_i = {4'h0, q[31:20]};
    cmd_valid_i = r[31];
    cmd_op_i = osg_pkg::osg_op_e'(c[3:0]);
    cmd_sel_i = osg_pkg::osg_mode_e'(c[5:4] == 2'h3 ? 2'h2 : c[5:4]);
    cmd_data_i = c[7:6] == 2'h0 ? 32'h0 : c[7:6] == 2'h1 ? 32'hffff_ffff : rnd();
    // Levels straddle the limit so both acceptance and refusal occur
    if (cmd_op_i == osg_pkg::OP_WR_UV_LEVEL) cmd_data_i = {16'h0, 16'(q % ({16'h0, setpoint_i} + 32'h100))};
  endtask : drive

  // Model and design both update on the rising edge, so compare on the falling one
  task automatic run(input int n);
    // Drive first, so the last command of a run is checked before any reset touches the inputs
    repeat (n) begin
      drive();
      @(negedge mclk_i);
      chk({31'h0, resp_valid_o}, {31'h0, m_rv});
      chk({31'h0, alarm_o}, {31'h0, m_alm});
      chk({30'h0, undervoltage_trip_o, setpoint_block_o}, {30'h0, m_trip, m_blk});
      if (m_rv) begin
        chk({31'h0, resp_err_o}, {31'h0, m_err});
        chk(resp_data_o, m_rdata);
        chk(resp_data_o, m_rdata);
      end
    end
  endtask : run

  task automatic do_reset();
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
  endtask : do_reset

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    seed = 32'hb4434fc9;
    err_total = 0;
    comparisons = 0;
    {ext_shutdown_pin_i, interlock_pin_i, cmd_data_i, fault_cond_i, fault_enable_i} = '0;
    {st, setpoint_i, measured_i} = '0;
    mode_i = osg_pkg::MODE_AC;
    cmd_sel_i = osg_pkg::MODE_AC;
    cmd_op_i = osg_pkg::OP_NOP;
    do_reset();
    run(2500);
    do_reset();
    run(2500);
    end_of_test();
  end
endmodule : tb_top

bind osg_top osg_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .status_i(status_i), .fault_cond_i(fault_cond_i),
  .fault_enable_i(fault_enable_i), .mode_i(mode_i), .setpoint_i(setpoint_i), .interlock_pin_i(interlock_pin_i),
  .ext_shutdown_pin_i(ext_shutdown_pin_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_sel_i(cmd_sel_i),
  .cmd_data_i(cmd_data_i), .resp_valid_o(resp_valid_o), .resp_err_o(resp_err_o), .resp_data_o(resp_data_o),
  .alarm_o(alarm_o), .undervoltage_trip_o(undervoltage_trip_o), .setpoint_block_o(setpoint_block_o));
